// ==== verilog/eqic_regs.vh ====
`ifndef EQIC_REGS_VH
`define EQIC_REGS_VH

// ****************************************
// Register indexes
// ****************************************
`define EQIC_ADDR_W          4
`define EQIC_IDX_CONTROL     4'h0
`define EQIC_IDX_INIT_VALUE  4'h1
`define EQIC_IDX_GE_COMPARE  4'h2
`define EQIC_IDX_POSITION    4'h3
`define EQIC_IDX_STATUS      4'h4

// ****************************************
// Control field positions
// ****************************************
`define EQIC_BIT_ENABLE      15
`define EQIC_BIT_IDLE_STOP   13
`define EQIC_MODE_HI         12
`define EQIC_MODE_LO         10
`define EQIC_BIT_MATCH_B     9
`define EQIC_BIT_MATCH_A     8
`define EQIC_CONTROL_MASK    16'hBF00
`define EQIC_CONTROL_RESET   16'h0000
`define EQIC_INIT_RESET      16'h0000
`define EQIC_COMPARE_RESET   16'h0000

// ****************************************
// Initialisation modes
// ****************************************
`define EQIC_MODE_NONE       3'h0
`define EQIC_MODE_EVERY_IDX  3'h1
`define EQIC_MODE_NEXT_IDX   3'h2
`define EQIC_MODE_FIRST_HOME 3'h3
`define EQIC_MODE_SECOND_HOME 3'h4
`define EQIC_MODE_GE_RESET   3'h5
`define EQIC_MODE_MODULO     3'h6
`define EQIC_MODE_RESERVED   3'h7

`endif

// ==== verilog/eqic_edge.v ====
`timescale 1ns/100ps
// ****************************************
// Rising edge detector
// ****************************************
module eqic_edge (
  // Clock and reset
  input  wire core_clk_in,
  input  wire rst_in,
  // Level in, pulse out
  input  wire level_in,
  output wire rise_out
);
  reg last;

  always @(posedge core_clk_in) begin
    if (rst_in) begin
      last <= 1'b0;
    end else begin
      last <= level_in;
    end
  end

  assign rise_out = level_in & ~last;
endmodule // eqic_edge

// ==== verilog/eqic_position_init.v ====
`timescale 1ns/100ps
`include "eqic_regs.vh"
// Functional notes
// - With the counter enable bit (bit 15) set, the position counter runs unless idle stop halts it or the mode is 111.
// - With it clear, counters stop but all registers stay accessible.
// - With idle stop set the block halts in Idle, otherwise it runs on.
// - Init mode is bits 12 to 10 and code 111 is reserved.
// - Mode 110 makes the position counter count modulo.
// - Mode 100 loads the init value on the second index after home.
// - Mode 011 loads the init value on the first index after home.
// - Mode 001 resets the counter on every qualified index.
// - Phase B match bit picks the phase B level that qualifies index.
// - Phase A match bit (bit 8) picks the phase A level for index.
module eqic_position_init (
  // Clock and reset
  input  wire        core_clk_in,
  input  wire        rst_in,
  // Register port
  input  wire [3:0]  reg_addr_in,
  input  wire [15:0] reg_wdata_in,
  input  wire        reg_write_in,
  input  wire        reg_read_in,
  output reg  [15:0] reg_rdata_out,
  // Device state
  input  wire        device_idle_in,
  // Encoder inputs
  input  wire        phase_a_input_in,
  input  wire        phase_b_input_in,
  input  wire        index_in,
  input  wire        home_in,
  // Status
  output reg  [15:0] position_out,
  output reg         running_out,
  output reg         init_event_out
);

  // ****************************************
  // Registers
  // ****************************************
  reg  [15:0] encoder_control;
  reg  [15:0] init_value_register;
  reg  [15:0] greater_equal_compare_register;
  reg  [1:0]  home_seen;
  reg         index_armed;
  reg  [1:0]  next_home_seen;
  reg         next_index_armed;
  reg  [15:0] next_position;
  reg         next_init_event;
  reg  [15:0] read_mux;

  wire        encoder_counter_enable;
  wire        idle_stop_select;
  wire [2:0]  position_init_mode;
  wire        phase_b_index_match;
  wire        phase_a_index_match;
  wire        index_rise;
  wire        home_rise;
  wire        index_match;
  wire        run;
  wire [15:0] count_up;

  assign encoder_counter_enable = encoder_control[`EQIC_BIT_ENABLE];
  assign idle_stop_select       = encoder_control[`EQIC_BIT_IDLE_STOP];
  assign position_init_mode     =
    encoder_control[`EQIC_MODE_HI:`EQIC_MODE_LO];
  assign phase_b_index_match    = encoder_control[`EQIC_BIT_MATCH_B];
  assign phase_a_index_match    = encoder_control[`EQIC_BIT_MATCH_A];

  // ****************************************
  // Edge detection
  // ****************************************
  eqic_edge u_index_edge (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .level_in    (index_in),
    .rise_out    (index_rise)
  );

  eqic_edge u_home_edge (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .level_in    (home_in),
    .rise_out    (home_rise)
  );

  // Index qualified by phase levels
  assign index_match = index_rise
    & (phase_b_input_in == phase_b_index_match)
    & (phase_a_input_in == phase_a_index_match);

  // Counting gate
  assign run = encoder_counter_enable
             & ~(idle_stop_select & device_idle_in);

  assign count_up = position_out + 16'h0001;

  // ****************************************
  // Register writes
  // ****************************************
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      encoder_control                <= `EQIC_CONTROL_RESET;
      init_value_register            <= `EQIC_INIT_RESET;
      greater_equal_compare_register <= `EQIC_COMPARE_RESET;
    end else if (reg_write_in) begin
      case (reg_addr_in)
        `EQIC_IDX_CONTROL: begin
          encoder_control <= reg_wdata_in & `EQIC_CONTROL_MASK;
        end
        `EQIC_IDX_INIT_VALUE: begin
          init_value_register <= reg_wdata_in;
        end
        `EQIC_IDX_GE_COMPARE: begin
          greater_equal_compare_register <= reg_wdata_in;
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // Position counter next state
  // ****************************************
  always @* begin
    next_position    = position_out;
    next_home_seen   = home_seen;
    next_index_armed = index_armed;
    next_init_event  = 1'b0;
    if (run) begin
      next_position = count_up;
      case (position_init_mode)
        `EQIC_MODE_NONE: begin
          next_home_seen = 2'h0;
        end
        `EQIC_MODE_EVERY_IDX: begin
          if (index_match) begin
            next_position   = 16'h0000;
            next_init_event = 1'b1;
          end
        end
        `EQIC_MODE_NEXT_IDX: begin
          if (index_match && index_armed) begin
            next_position    = init_value_register;
            next_index_armed = 1'b0;
            next_init_event  = 1'b1;
          end
        end
        `EQIC_MODE_FIRST_HOME: begin
          if (home_rise) begin
            next_home_seen = 2'h1;
          end else if (index_match && home_seen == 2'h1) begin
            next_position   = init_value_register;
            next_home_seen  = 2'h0;
            next_init_event = 1'b1;
          end
        end
        `EQIC_MODE_SECOND_HOME: begin
          if (home_rise) begin
            next_home_seen = 2'h1;
          end else if (index_match && home_seen == 2'h1) begin
            next_home_seen = 2'h2;
          end else if (index_match && home_seen == 2'h2) begin
            next_position   = init_value_register;
            next_home_seen  = 2'h0;
            next_init_event = 1'b1;
          end
        end
        `EQIC_MODE_GE_RESET: begin
          if (position_out == greater_equal_compare_register) begin
            next_position   = 16'h0000;
            next_init_event = 1'b1;
          end
        end
        `EQIC_MODE_MODULO: begin
          if (position_out == greater_equal_compare_register) begin
            next_position   = init_value_register;
            next_init_event = 1'b1;
          end
        end
        default: begin
          next_position = position_out;
        end
      endcase
    end
    if (reg_write_in && reg_addr_in == `EQIC_IDX_CONTROL) begin
      next_index_armed = 1'b1;
      next_home_seen   = 2'h0;
    end
  end

  // ****************************************
  // State registers
  // ****************************************
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      position_out   <= 16'h0000;
      home_seen      <= 2'h0;
      index_armed    <= 1'b0;
      init_event_out <= 1'b0;
      running_out    <= 1'b0;
    end else begin
      position_out   <= next_position;
      home_seen      <= next_home_seen;
      index_armed    <= next_index_armed;
      init_event_out <= next_init_event;
      running_out    <= run;
    end
  end

  // ****************************************
  // Register reads
  // ****************************************
  always @* begin
    case (reg_addr_in)
      `EQIC_IDX_CONTROL:    read_mux = encoder_control;
      `EQIC_IDX_INIT_VALUE: read_mux = init_value_register;
      `EQIC_IDX_GE_COMPARE: read_mux = greater_equal_compare_register;
      `EQIC_IDX_POSITION:   read_mux = position_out;
      `EQIC_IDX_STATUS:     read_mux = {12'h000, index_armed,
                                        home_seen, run};
      default:              read_mux = 16'h0000;
    endcase
  end

  always @(posedge core_clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (reg_read_in) begin
      reg_rdata_out <= read_mux;
    end else begin
      reg_rdata_out <= 16'h0000;
    end
  end
endmodule // eqic_position_init

// ==== sim/eqic_position_init_props.sv ====
`timescale 1ns/100ps
// ****************************************
// Position init checker
// ****************************************
module eqic_position_init_props (
  input wire        core_clk_in,
  input wire        rst_in,
  input wire [3:0]  reg_addr_in,
  input wire [15:0] reg_wdata_in,
  input wire        reg_write_in,
  input wire        reg_read_in,
  input wire [15:0] reg_rdata_out,
  input wire        device_idle_in,
  input wire        phase_a_input_in,
  input wire        phase_b_input_in,
  input wire        index_in,
  input wire        home_in,
  input wire [15:0] position_out,
  input wire        running_out,
  input wire        init_event_out
);
  reg  [15:0] ctl;
  reg  [15:0] ge;
  reg  [15:0] ival;
  wire        run  = ctl[15] & ~(ctl[13] & device_idle_in);
  wire [2:0]  mode = ctl[12:10];
  wire        hit  = phase_a_input_in == ctl[8] && phase_b_input_in == ctl[9];
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      ctl <= 16'h0000;
      ge <= 16'h0000;
      ival <= 16'h0000;
    end else if (reg_write_in) begin
      if (reg_addr_in == 4'h0) ctl <= reg_wdata_in;
      if (reg_addr_in == 4'h1) ival <= reg_wdata_in;
      if (reg_addr_in == 4'h2) ge <= reg_wdata_in;
    end
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  a_run_follows_en: assert property (
    1 |=> running_out == $past(run)) else $error("run flag wrong");
  a_stop_holds: assert property (
    !run |=> $stable(position_out)) else $error("count while stopped");
  a_count_plain: assert property (
    run && mode == 3'h0 |=> position_out == $past(position_out) + 16'h0001)
    else $error("plain count wrong");
  a_every_idx: assert property (
    run && mode == 3'h1 && index_in && !$past(index_in) && hit
    |=> position_out == 16'h0000 && init_event_out)
    else $error("index reset missed");
  a_ge_reset: assert property (
    run && mode == 3'h5 && position_out == ge |=> position_out == 16'h0000)
    else $error("compare reset missed");
  a_modulo_wrap: assert property (
    run && mode == 3'h6 && position_out == ge |=> position_out == ival)
    else $error("modulo wrap wrong");
  a_event_value: assert property (
    init_event_out && mode inside {3'h2, 3'h3, 3'h4} |-> position_out == ival)
    else $error("init load wrong");
  a_ctl_readback: assert property (
    reg_read_in && reg_addr_in == 4'h0
    |=> reg_rdata_out == ($past(ctl) & 16'hBF00))
    else $error("control readback wrong");
  a_idx_unmatched: assert property (
    run && mode == 3'h1 && index_in && !$past(index_in) && !hit
    |=> position_out == $past(position_out) + 16'h0001)
    else $error("unqualified index acted");
  a_reserved_hold: assert property (
    run && mode == 3'h7 |=> $stable(position_out))
    else $error("reserved mode moved counter");
  a_plain_no_event: assert property (
    run && mode == 3'h0 |=> !init_event_out)
    else $error("event in plain mode");
endmodule // eqic_position_init_props

bind eqic_position_init eqic_position_init_props u_props (.*);

// ==== sim/eqic_encoder_model.sv ====
`timescale 1ns/100ps
// ****************************************
// Encoder far side
// ****************************************
module eqic_encoder_model (
  input  wire core_clk_in,
  output reg  phase_a_out,
  output reg  phase_b_out,
  output reg  index_out,
  output reg  home_out
);
  initial begin
    phase_a_out = 1'b0;
    phase_b_out = 1'b0;
    index_out = 1'b0;
    home_out = 1'b0;
  end
  // One index or home pulse at given phases
  task pulse(input logic is_home, input logic a, input logic b);
    @(posedge core_clk_in);
    phase_a_out <= a;
    phase_b_out <= b;
    if (is_home) home_out <= 1'b1;
    else index_out <= 1'b1;
    @(posedge core_clk_in);
    index_out <= 1'b0;
    home_out <= 1'b0;
    phase_a_out <= ~a;
  endtask
endmodule // eqic_encoder_model

// ==== sim/eqic_position_init_tb.sv ====
`timescale 1ns/100ps
module eqic_position_init_tb;
  reg          core_clk_in, rst_in, reg_write_in, reg_read_in;
  reg          device_idle_in, rd_d;
  reg   [3:0]  reg_addr_in;
  reg   [15:0] reg_wdata_in, ctl, ival;
  wire  [15:0] reg_rdata_out, position_out;
  wire         running_out, init_event_out, pa, pb, idx, hm;
  logic [15:0] exp_q[$], ev_q[$], ev_exp;
  reg          ev_on;
  int          ev_seen, ev_n;
  int          mismatches, check_count, m;
  eqic_position_init dut (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
    .reg_rdata_out(reg_rdata_out), .device_idle_in(device_idle_in),
    .phase_a_input_in(pa), .phase_b_input_in(pb), .index_in(idx),
    .home_in(hm), .position_out(position_out), .running_out(running_out),
    .init_event_out(init_event_out));
  eqic_encoder_model enc (.core_clk_in(core_clk_in), .phase_a_out(pa),
    .phase_b_out(pb), .index_out(idx), .home_out(hm));
  initial begin
    core_clk_in = 1'b0;
    forever #25 core_clk_in = ~core_clk_in;
  end
  task compare(input logic [15:0] e, input logic [15:0] s);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED reg_rdata_out expected %h seen %h", e, s);
    end
  endtask
  task compare_event(input logic [15:0] e, input logic [15:0] s);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED position_out expected %h seen %h", e, s);
    end
  endtask
  task compare_count(input int e, input int s);
    check_count++;
    if (s != e) begin
      mismatches++;
      $display("CHECK FAILED init_event_out expected %0d seen %0d", e, s);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    @(posedge core_clk_in);
    reg_write_in <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    exp_q.push_back(e);
    @(posedge core_clk_in);
    reg_read_in <= 1'b0;
  endtask
  always @(posedge core_clk_in) begin
    if (rd_d) compare(exp_q.pop_front(), reg_rdata_out);
    rd_d <= reg_read_in;
  end
  always @(posedge core_clk_in) begin
    if (!ev_on) begin
      ev_seen <= 0;
    end else if (init_event_out === 1'b1) begin
      ev_seen <= ev_seen + 1;
      if (ev_q.size() > 0) begin
        ev_exp = ev_q.pop_front();
        compare_event(ev_exp, position_out);
      end
    end
  end
  initial begin
    #1_000_000;
    mismatches++;
    end_sim;
  end
  initial begin
    {rst_in, reg_write_in, reg_read_in, rd_d, device_idle_in} = 5'b10000;
    reg_addr_in = 4'h0;
    ev_on = 1'b0;
    reg_wdata_in = 16'h0000;
    m = $urandom(85);
    repeat (20) @(posedge core_clk_in);
    rst_in <= 1'b0;
    rd(4'h0, 16'h0000);
    rd(4'h3, 16'h0000);
    ival = 16'($urandom % 16);
    wr(4'h1, ival);
    rd(4'h1, ival);
    wr(4'h0, 16'hFFFF);
    rd(4'h0, 16'hBF00);
    rd(4'hF, 16'h0000);
    $display("test registers done");
    wr(4'h0, 16'hA000);
    device_idle_in <= 1'b1;
    rd(4'h3, 16'h0000);
    rd(4'h4, 16'h0008);
    wr(4'h0, 16'h8000);
    rd(4'h4, 16'h0009);
    repeat (5) @(posedge core_clk_in);
    device_idle_in <= 1'b0;
    $display("test idle stop done");
    for (m = 0; m < 7; m++) begin
      wr(4'h0, 16'h8400);
      enc.pulse(1'b0, 1'b0, 1'b0);
      wr(4'h2, 16'h0010 + 16'($urandom % 16));
      ctl = {1'b1, 2'b00, 3'(m), 2'($urandom), 8'h00};
      wr(4'h0, ctl);
      rd(4'h0, ctl);
      ev_n = 0;
      if (m == 1) begin
        ev_q.push_back(16'h0000);
        ev_q.push_back(16'h0000);
        ev_n = 2;
      end else if (m >= 2 && m <= 4) begin
        ev_q.push_back(ival);
        ev_n = 1;
      end
      if (m < 5) begin
        ev_on <= 1'b1;
        enc.pulse(1'b0, ~ctl[8], ctl[9]);
        enc.pulse(1'b0, ctl[8], ~ctl[9]);
        enc.pulse(1'b1, ~ctl[8], ~ctl[9]);
        enc.pulse(1'b0, ctl[8], ctl[9]);
        enc.pulse(1'b0, ctl[8], ctl[9]);
        repeat (3) @(posedge core_clk_in);
        compare_count(ev_n, ev_seen);
        ev_on <= 1'b0;
        ev_q.delete();
      end
      repeat (4) begin
        enc.pulse(1'b1, 1'($urandom), 1'($urandom));
        enc.pulse(1'b0, ctl[8], ctl[9]);
        enc.pulse(1'b0, ctl[8], ctl[9]);
        enc.pulse(1'b0, 1'($urandom), 1'($urandom));
      end
      $display("test mode %0d done", m);
    end
    end_sim;
  end
endmodule // eqic_position_init_tb
